// *** core/rot_sleep_map.svh ***
// Register offsets, field positions, opcodes and constants of the rotate and sleep unit
`ifndef ROT_SLEEP_MAP_SVH
`define ROT_SLEEP_MAP_SVH

// ****************************************
// Register byte offsets and file-select address bit
// ****************************************
`define RS_INSTR_OFS 8'h00
`define RS_WREG_OFS 8'h04
`define RS_STATUS_OFS 8'h08
`define RS_WDOG_OFS 8'h0c
`define RS_FILE_BIT 7

// ****************************************
// Status and watchdog field positions
// ****************************************
`define RS_ST_CARRY 0
`define RS_ST_PWRDN_N 3
`define RS_ST_EXPIRY_N 4
`define RS_ST_ASLEEP 8
`define RS_WD_ASSIGN 0
`define RS_WD_CNT_LSB 8
`define RS_WD_PRE_LSB 16

// ****************************************
// Opcodes and constants
// ****************************************
`define RS_OP_ROTL 6'h0d
`define RS_OP_ROTR 6'h0c
`define RS_OP_SLEEP 12'h003
`define RS_WDOG_CLEAR 8'h00
`define RS_HTRANS_NONSEQ 2'h2
`define RS_HRESP_OKAY 1'h0

`endif

// *** core/rot_sleep_pkg.sv ***
// Types shared by the rotate and sleep unit
package rot_sleep_pkg;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  typedef struct packed {
    logic [31:0][7:0] file;
    logic [7:0] wreg;
    logic carry;
    logic watchdog_expiry_flag_n;
    logic powerdown_flag_n;
    logic asleep;
    logic [7:0] wdog;
    logic [7:0] presc;
    logic presc_assigned;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic wake_s1;
    logic wake_s2;
  } state_t;

endpackage : rot_sleep_pkg

// *** core/rotate_and_sleep_instructions.sv ***
// Rotate-through-carry and sleep execution unit with an AHB-Lite register slave
`timescale 1ns/1ps
`include "rot_sleep_map.svh"

// Contract
// - Opcode 0011 01df ffff rotates file register left through carry, nine-bit loop.
// - Opcode 0011 00df ffff rotates file register right through carry, nine-bit loop.
// - Carry is status bit 0; takes bit shifted out, feeds vacated bit.
// - Destination bit 0 writes result to working register, file unchanged.
// - Destination bit 1 writes result back into the addressed file register.
// - Sleep opcode 0000 0000 0011 sets the active-low timeout flag to one.
// - Sleep opcode clears the active-low power-down flag to zero.
// - Sleep clears watchdog counter to 00h, prescaler too when assigned to it.
// - After sleep, execution halts and the oscillator stops, staying asleep until the synchronised wake pin goes high.
module rotate_and_sleep_instructions (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // AHB-Lite slave
  input wire rot_sleep_pkg::ahb_req_t ahb_req_i,
  output rot_sleep_pkg::ahb_rsp_t ahb_rsp_o,
  // Wake pin and oscillator control
  input wire logic wake_i,
  output logic osc_stop_o
);
  import rot_sleep_pkg::*;

  state_t cur_ff;
  state_t nxt_st;

  // ****************************************
  // Instruction decode
  // ****************************************
  logic [11:0] op;
  logic [4:0] fidx;
  logic dest_file;
  logic instr_wr;
  logic exec_rotl;
  logic exec_rotr;
  logic exec_rot;
  logic exec_sleep;
  logic [7:0] src;
  logic [7:0] rot_res;
  logic rot_carry;
  logic addr_ok;
  logic [7:0] a_lo;
  logic [31:0] rd_val;

  assign op = ahb_req_i.hwdata[11:0];
  assign fidx = op[4:0];
  assign dest_file = op[5];
  assign instr_wr = cur_ff.wr_pend && (cur_ff.wr_addr == `RS_INSTR_OFS) && !cur_ff.asleep;
  assign exec_rotl = instr_wr && (op[11:6] == `RS_OP_ROTL);
  assign exec_rotr = instr_wr && (op[11:6] == `RS_OP_ROTR);
  assign exec_rot = exec_rotl || exec_rotr;
  assign exec_sleep = instr_wr && (op == `RS_OP_SLEEP);
  assign src = cur_ff.file[fidx];

  always_comb begin
    if (exec_rotl) begin
      rot_res = {src[6:0], cur_ff.carry};
      rot_carry = src[7];
    end else begin
      rot_res = {cur_ff.carry, src[7:1]};
      rot_carry = src[0];
    end
  end

  assign a_lo = ahb_req_i.haddr[7:0];
  assign addr_ok = ahb_req_i.hsel && ahb_req_i.hready && (ahb_req_i.htrans == `RS_HTRANS_NONSEQ);

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (a_lo[`RS_FILE_BIT]) begin
      rd_val[7:0] = cur_ff.file[a_lo[6:2]];
    end else begin
      case (a_lo)
        `RS_WREG_OFS: rd_val[7:0] = cur_ff.wreg;
        `RS_STATUS_OFS: begin
          rd_val[`RS_ST_CARRY] = cur_ff.carry;
          rd_val[`RS_ST_PWRDN_N] = cur_ff.powerdown_flag_n;
          rd_val[`RS_ST_EXPIRY_N] = cur_ff.watchdog_expiry_flag_n;
          rd_val[`RS_ST_ASLEEP] = cur_ff.asleep;
        end
        `RS_WDOG_OFS: begin
          rd_val[`RS_WD_ASSIGN] = cur_ff.presc_assigned;
          rd_val[`RS_WD_CNT_LSB +: 8] = cur_ff.wdog;
          rd_val[`RS_WD_PRE_LSB +: 8] = cur_ff.presc;
        end
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.wake_s1 = wake_i;
    nxt_st.wake_s2 = cur_ff.wake_s1;
    // Watchdog time base
    if (cur_ff.presc_assigned) begin
      nxt_st.presc = cur_ff.presc + 8'h01;
      if (cur_ff.presc == 8'hff) begin
        nxt_st.wdog = cur_ff.wdog + 8'h01;
      end
    end else begin
      nxt_st.wdog = cur_ff.wdog + 8'h01;
    end
    if (cur_ff.asleep && cur_ff.wake_s2) begin
      nxt_st.asleep = 1'b0;
    end
    // Data phase of a write
    if (cur_ff.wr_pend) begin
      if (cur_ff.wr_addr[`RS_FILE_BIT]) begin
        nxt_st.file[cur_ff.wr_addr[6:2]] = ahb_req_i.hwdata[7:0];
      end else begin
        case (cur_ff.wr_addr)
          `RS_WREG_OFS: nxt_st.wreg = ahb_req_i.hwdata[7:0];
          `RS_STATUS_OFS: nxt_st.carry = ahb_req_i.hwdata[`RS_ST_CARRY];
          `RS_WDOG_OFS: nxt_st.presc_assigned = ahb_req_i.hwdata[`RS_WD_ASSIGN];
          default: nxt_st.wreg = cur_ff.wreg;
        endcase
      end
    end
    if (exec_rot) begin
      nxt_st.carry = rot_carry;
      if (dest_file) begin
        nxt_st.file[fidx] = rot_res;
      end else begin
        nxt_st.wreg = rot_res;
      end
    end
    if (exec_sleep) begin
      nxt_st.watchdog_expiry_flag_n = 1'b1;
      nxt_st.powerdown_flag_n = 1'b0;
      nxt_st.wdog = `RS_WDOG_CLEAR;
      if (cur_ff.presc_assigned) begin
        nxt_st.presc = `RS_WDOG_CLEAR;
      end
      nxt_st.asleep = 1'b1;
    end
    // Address phase
    nxt_st.wr_pend = addr_ok && ahb_req_i.hwrite;
    nxt_st.wr_addr = a_lo;
    if (addr_ok && !ahb_req_i.hwrite) begin
      nxt_st.rdata = rd_val;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_ff <= '0;
      cur_ff.watchdog_expiry_flag_n <= 1'b1;
      cur_ff.powerdown_flag_n <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ahb_rsp_o.hrdata = cur_ff.rdata;
  assign ahb_rsp_o.hreadyout = 1'b1;
  assign ahb_rsp_o.hresp = `RS_HRESP_OKAY;
  assign osc_stop_o = cur_ff.asleep;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_rotl_value: assert property (exec_rotl && !dest_file |=>
    cur_ff.wreg == {$past(src[6:0]), $past(cur_ff.carry)})
    else $error("left rotate result wrong");
  a_rotr_value: assert property (exec_rotr && dest_file |=>
    cur_ff.file[$past(fidx)] == {$past(cur_ff.carry), $past(src[7:1])})
    else $error("right rotate result wrong");
  a_carry_out: assert property (exec_rot |=>
    cur_ff.carry == $past(exec_rotl ? src[7] : src[0]))
    else $error("carry not taken from shifted-out bit");
  a_dest_work: assert property (exec_rot && !dest_file |=> $stable(cur_ff.file))
    else $error("file changed on working-register destination");
  a_dest_file: assert property (exec_rot && dest_file |=> $stable(cur_ff.wreg))
    else $error("working register changed on file destination");
  a_sleep_to: assert property (exec_sleep |=> cur_ff.watchdog_expiry_flag_n)
    else $error("timeout flag not set by sleep");
  a_sleep_pd: assert property (exec_sleep |=>
    !cur_ff.powerdown_flag_n ##1 !cur_ff.powerdown_flag_n)
    else $error("power-down flag not cleared by sleep");
  a_sleep_wdog: assert property (exec_sleep |=> cur_ff.wdog == `RS_WDOG_CLEAR
    && (!$past(cur_ff.presc_assigned) || cur_ff.presc == `RS_WDOG_CLEAR))
    else $error("watchdog not cleared by sleep");
  a_sleep_halt: assert property (exec_sleep && !cur_ff.wake_s1 |=> osc_stop_o [*2])
    else $error("oscillator not stopped after sleep");
  a_stay_asleep: assert property (osc_stop_o && !cur_ff.wake_s2 |=> osc_stop_o)
    else $error("left sleep without wake");
  a_asleep_ignore: assert property (cur_ff.asleep && cur_ff.wr_pend
    && cur_ff.wr_addr == `RS_INSTR_OFS |=> $stable(cur_ff.carry) && $stable(cur_ff.wreg))
    else $error("instruction executed while asleep");
  a_rot_flags: assert property (exec_rot |=>
    $stable(cur_ff.watchdog_expiry_flag_n) && $stable(cur_ff.powerdown_flag_n))
    else $error("rotate touched power flags");

  c_rotl: cover property (exec_rotl ##1 exec_rotr);
  c_sleep: cover property (exec_sleep);
  c_sleep_assigned: cover property (exec_sleep && cur_ff.presc_assigned);
  c_wake: cover property (osc_stop_o ##1 !osc_stop_o);
  c_ignored: cover property (cur_ff.asleep && cur_ff.wr_pend && cur_ff.wr_addr == `RS_INSTR_OFS);

endmodule : rotate_and_sleep_instructions

// *** tb/rotate_and_sleep_instructions_test.sv ***
// Bus-driven test of rotate-through-carry and sleep execution
`timescale 1ns/1ps
`include "rot_sleep_map.svh"

module rotate_and_sleep_instructions_test;
  import rot_sleep_pkg::*;
  // ****************************************
  // Clock, reset and bus signals
  // ****************************************
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wake_i = 1'b0;
  logic osc_stop_o;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  ahb_req_t ahb_req;
  ahb_rsp_t ahb_rsp;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] v;
  logic [7:0] p;
  localparam logic [31:0] EXPF = 32'h1 << `RS_ST_EXPIRY_N;
  localparam logic [31:0] PWRF = 32'h1 << `RS_ST_PWRDN_N;
  localparam logic [31:0] SL = 32'h1 << `RS_ST_ASLEEP;
  localparam logic [31:0] INS = {24'h0, `RS_INSTR_OFS};
  localparam logic [31:0] WR = {24'h0, `RS_WREG_OFS};
  localparam logic [31:0] ST = {24'h0, `RS_STATUS_OFS};
  localparam logic [31:0] WD = {24'h0, `RS_WDOG_OFS};

  assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                     hsize: 3'h2, hwdata: hwdata, hready: ahb_rsp.hreadyout};

  always #2 ref_clk_i = ~ref_clk_i;

  rotate_and_sleep_instructions rotate_and_sleep_instructions_i (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ahb_req_i(ahb_req),
    .ahb_rsp_o(ahb_rsp), .wake_i(wake_i), .osc_stop_o(osc_stop_o));

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= `RS_HTRANS_NONSEQ;
    do @(posedge ref_clk_i); while (ahb_rsp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (ahb_rsp.hreadyout !== 1'b1);
    r = ahb_rsp.hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] fa(input int i);
    return 32'h80 + 32'(4 * i);
  endfunction : fa

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(ST, v); chk(v, EXPF | PWRF);
    wr(fa(5), 32'he6);
    wr(ST, 32'h0);
    wr(INS, {20'h0, `RS_OP_ROTL, 1'b0, 5'd5});
    rd(WR, v); chk(v, 32'hcc);
    rd(ST, v); chk(v, EXPF | PWRF | 32'h1);
    rd(fa(5), v); chk(v, 32'he6);
    wr(INS, {20'h0, `RS_OP_ROTR, 1'b1, 5'd5});
    rd(fa(5), v); chk(v, 32'hf3);
    rd(ST, v); chk(v, EXPF | PWRF);
    wr(fa(31), 32'h80);
    wr(INS, {20'h0, `RS_OP_ROTL, 1'b1, 5'd31});
    rd(ST, v); chk(v, EXPF | PWRF | 32'h1);
    wr(INS, {20'h0, `RS_OP_ROTL, 1'b1, 5'd31});
    rd(fa(31), v); chk(v, 32'h01);
    rd(ST, v); chk(v, EXPF | PWRF);
    wr(WD, 32'h1);
    repeat (600) @(posedge ref_clk_i);
    rd(WD, v); chk({31'h0, v[15:8] != 8'h0}, 32'h1);
    wr(INS, {20'h0, `RS_OP_SLEEP});
    @(posedge ref_clk_i);
    chk({31'h0, osc_stop_o}, 32'h1);
    rd(ST, v); chk(v, EXPF | SL);
    rd(WD, v); chk({24'h0, v[15:8]}, 32'h0);
    chk({31'h0, v[23:16] < 8'h8}, 32'h1);
    wr(WR, 32'h5a);
    wr(INS, {20'h0, `RS_OP_ROTL, 1'b0, 5'd5});
    rd(WR, v); chk(v, 32'h5a);
    @(posedge ref_clk_i) wake_i <= 1'b1;
    for (int i = 0; i < 20 && osc_stop_o !== 1'b0; i++) @(posedge ref_clk_i);
    chk({31'h0, osc_stop_o}, 32'h0);
    wake_i <= 1'b0;
    rd(ST, v); chk(v, EXPF);
    wr(WD, 32'h0);
    repeat (40) @(posedge ref_clk_i);
    rd(WD, v);
    p = v[23:16];
    wr(INS, {20'h0, `RS_OP_SLEEP});
    rd(WD, v); chk({24'h0, v[23:16]}, {24'h0, p});
    chk({31'h0, v[15:8] < 8'h8}, 32'h1);
    rd(ST, v); chk(v, EXPF | SL);
    rd(32'h40, v); chk(v, 32'h0);
    chk({31'h0, ahb_rsp.hresp}, 32'h0);
    conclude();
  end
endmodule : rotate_and_sleep_instructions_test
